// ---- rtl/pfm_pkg.sv ----
// package: constants and types for the pulse frequency speed meter
package pfm_pkg;
    // -------------------------------------------------------------
    // clock and timing
    // -------------------------------------------------------------
    localparam int unsigned CLK_HZ         = 125_000_000;
    localparam int unsigned SAMPLE_10_MS   = 10;
    localparam int unsigned SAMPLE_100_MS  = 100;
    localparam int unsigned SAMPLE_1S_MS   = 1000;
    localparam int unsigned STD_TIMEOUT_MS = 1000;
    localparam int unsigned WIN10_CYC      = CLK_HZ / 1000 * SAMPLE_10_MS;
    localparam int unsigned WIN100_CYC     = CLK_HZ / 1000 * SAMPLE_100_MS;
    localparam int unsigned WIN1S_CYC      = CLK_HZ / 1000 * SAMPLE_1S_MS;
    localparam int unsigned STD_TIMEOUT_CYC = CLK_HZ / 1000 * STD_TIMEOUT_MS;
    // -------------------------------------------------------------
    // frequency limits
    // -------------------------------------------------------------
    localparam logic [31:0] FREQ_MAX_1X = 32'h0001_86A0;
    localparam logic [31:0] FREQ_MAX_4X = 32'h0003_0D40;
    localparam logic [31:0] LOW_FREQ_HZ = 32'h0000_03E8;
    localparam logic [31:0] CLK_HZ_W    = 32'h0773_5940;
    // -------------------------------------------------------------
    // register map
    // -------------------------------------------------------------
    localparam logic [7:0] REG_READ_CMD  = 8'h00;
    localparam logic [7:0] REG_CONV_CMD  = 8'h04;
    localparam logic [7:0] REG_RESULT_LO = 8'h08;
    localparam logic [7:0] REG_RESULT_HI = 8'h0C;
    localparam logic [7:0] REG_STATUS    = 8'h10;
    localparam int unsigned ST_DONE = 0;
    localparam int unsigned ST_ERR  = 1;
    localparam int unsigned ST_CY   = 2;
    localparam int unsigned ST_BUSY = 3;
    // -------------------------------------------------------------
    // command codes
    // -------------------------------------------------------------
    localparam logic [15:0] RD_CMP         = 16'h0002;
    localparam logic [15:0] RD_FREQ_STD    = 16'h0003;
    localparam logic [15:0] RD_FREQ_10     = 16'h0013;
    localparam logic [15:0] RD_FREQ_100    = 16'h0023;
    localparam logic [15:0] RD_FREQ_1S     = 16'h0033;
    localparam logic [15:0] PORT_POUT_LAST = 16'h0003;
    localparam logic [15:0] PORT_HSC0      = 16'h0010;
    localparam logic [15:0] CONV_TOTAL     = 16'h0001;
    localparam logic [3:0]  METH_MAX       = 4'h3;
    localparam logic [3:0]  UNIT_MAX       = 4'h2;
    localparam logic [11:0] MUL_RPM        = 12'h03C;
    localparam logic [11:0] MUL_RPS        = 12'h001;
    localparam logic [11:0] MUL_RPH        = 12'hE10;
    localparam logic [31:0] SCALE_10       = 32'h0000_0064;
    localparam logic [31:0] SCALE_100      = 32'h0000_000A;
    localparam logic [31:0] SCALE_1S       = 32'h0000_0001;

    typedef enum logic [1:0] {METH_STD, METH_10MS, METH_100MS, METH_1S} pfm_meth_t;
    typedef enum logic {CMD_IDLE, CMD_CALC} pfm_cmd_t;
endpackage

// ---- rtl/pfm_top.sv ----
// file: frequency meter, speed converter and AHB-Lite register slave
// Functional notes
// [RULE_01] non-4x input: frequency 0..100000, held at maximum above 100 kHz
// [RULE_02] 4x differential input: frequency 0..200000, held at maximum above 200 kHz
// [RULE_03] standard method measures each pulse, whatever the rate; code skips pulses while dividing and reads 0 after STD_TIMEOUT_CYC
// [RULE_04] high-frequency method counts pulses over a fixed sampling window
// [RULE_05] read codes 0013, 0023, 0033 pick 10 ms, 100 ms, 1 s windows
// [RULE_06] below 1 kHz the per-pulse result is used even with a window
// [RULE_07] windowed result refreshes once per sampling window
// [RULE_08] counter reset inside a window sets carry flag on the read
// [RULE_09] frequency read returns pulse output or counter 0 frequency, two words
// [RULE_10] read code 0002 returns current range comparison bits
// [RULE_11] lowest control digit: 0 frequency-to-speed, 1 value-to-revolutions
// [RULE_12] method digit: 0 standard, 1/2/3 windows of 10/100/1000 ms
// [RULE_13] unit digit: 0 per minute, 1 per second, 2 per hour
// [RULE_14] requester gives pulses per revolution 0001..FFFF; zero is an error
// [RULE_15] error flag set on disabled counter, bad control or zero coefficient
// [RULE_16] conversion result is unsigned 32 bits over two words
// [RULE_17] frequency measurement only on counter 0; others are rejected
// [RULE_18] per minute speed is frequency over coefficient times 60
// [RULE_19] total revolutions is counter value over coefficient
// [RULE_20] quotients truncate toward zero

// -----------------------------------------------------------------
// sequential unsigned divider, one quotient bit per clock
// -----------------------------------------------------------------
module pfm_div (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        start,
    input  wire logic [31:0] dividend,
    input  wire logic [31:0] divisor,
    output logic             busy,
    output logic             done,
    output logic [31:0]      quot
);
    logic [31:0] rem_ff;
    logic [31:0] den_ff;
    logic [5:0]  cnt_ff;
    logic [32:0] shifted;
    logic [32:0] diff;

    assign shifted = {rem_ff, quot[31]};
    assign diff    = shifted - {1'b0, den_ff};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rem_ff <= 32'h0000_0000;
            den_ff <= 32'h0000_0000;
            quot   <= 32'h0000_0000;
            cnt_ff <= 6'h00;
            busy   <= 1'b0;
            done   <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                rem_ff <= 32'h0000_0000;
                den_ff <= divisor;
                quot   <= dividend;
                cnt_ff <= 6'h00;
                busy   <= 1'b1;
            end else if (busy) begin
                if (!diff[32]) begin // [RULE_20]
                    rem_ff <= diff[31:0];
                    quot   <= {quot[30:0], 1'b1};
                end else begin
                    rem_ff <= shifted[31:0];
                    quot   <= {quot[30:0], 1'b0};
                end
                cnt_ff <= cnt_ff + 6'h01;
                if (cnt_ff == 6'h1F) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule // pfm_div

module pfm_top #(
    parameter int unsigned WIN10_CYC       = pfm_pkg::WIN10_CYC,
    parameter int unsigned WIN100_CYC      = pfm_pkg::WIN100_CYC,
    parameter int unsigned WIN1S_CYC       = pfm_pkg::WIN1S_CYC,
    parameter int unsigned STD_TIMEOUT_CYC = pfm_pkg::STD_TIMEOUT_CYC
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic [31:0]       hrdata,
    output logic              hreadyout,
    output logic              hresp,
    input  wire logic         cnt_strobe,
    input  wire logic         cnt_reset,
    input  wire logic         cnt_enabled,
    input  wire logic         four_x_mode,
    input  wire logic [31:0]  cnt_pv,
    input  wire logic         cmp_active,
    input  wire logic [31:0]  cmp_results,
    input  wire logic [127:0] pout_freq
);
    // -------------------------------------------------------------
    // declarations
    // -------------------------------------------------------------
    pfm_pkg::pfm_meth_t meth_ff, c_meth;
    pfm_pkg::pfm_cmd_t  state_ff;
    logic [31:0]        per_cnt_ff, std_freq_ff, win_cnt_ff, edge_cnt_ff, rep_freq_ff;
    logic [31:0]        win_len, scale, nxt_edge, win_freq, freq_max, sdiv_q, cdiv_q;
    logic [31:0]        rd_cmd_ff, conv_cmd_ff, result_ff, c_res, c_a, rd_mux;
    logic [11:0]        mul_ff, c_mul;
    logic [7:0]         ph_addr_ff;
    logic               bad_cur_ff, last_bad_ff, win_end, meth_chg, sdiv_done, cdiv_done;
    logic               ph_wr_ff, acc, err_ff, cy_ff, done_ff, rd_go, cv_go, c_err, c_win, c_div;

    assign freq_max = four_x_mode ? pfm_pkg::FREQ_MAX_4X : pfm_pkg::FREQ_MAX_1X; // [RULE_02]

    function automatic logic [31:0] sat(input logic [31:0] f, input logic [31:0] m);
        return (f > m) ? m : f; // [RULE_01] [RULE_02]
    endfunction

    // -------------------------------------------------------------
    // per-pulse frequency
    // -------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            per_cnt_ff <= 32'h0000_0000;
        end else if (cnt_strobe) begin
            per_cnt_ff <= 32'h0000_0000;
        end else if (per_cnt_ff != STD_TIMEOUT_CYC) begin
            per_cnt_ff <= per_cnt_ff + 32'h0000_0001;
        end
    end

    pfm_div u_sdiv (
        .clk      (hclk),
        .rst_n    (hresetn),
        .start    (cnt_strobe), // [RULE_03]
        .dividend (pfm_pkg::CLK_HZ_W),
        .divisor  (per_cnt_ff + 32'h0000_0001),
        .busy     (),
        .done     (sdiv_done),
        .quot     (sdiv_q)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            std_freq_ff <= 32'h0000_0000;
        end else if (per_cnt_ff == STD_TIMEOUT_CYC) begin
            std_freq_ff <= 32'h0000_0000;
        end else if (sdiv_done) begin
            std_freq_ff <= sat(sdiv_q, freq_max); // [RULE_03]
        end
    end

    // -------------------------------------------------------------
    // windowed frequency
    // -------------------------------------------------------------
    always_comb begin
        case (meth_ff)
            pfm_pkg::METH_10MS: begin
                win_len = WIN10_CYC;
                scale   = pfm_pkg::SCALE_10;
            end
            pfm_pkg::METH_100MS: begin
                win_len = WIN100_CYC;
                scale   = pfm_pkg::SCALE_100;
            end
            default: begin
                win_len = WIN1S_CYC;
                scale   = pfm_pkg::SCALE_1S;
            end
        endcase
    end

    assign nxt_edge = edge_cnt_ff + {31'h0000_0000, cnt_strobe};
    assign win_freq = 32'(nxt_edge * scale); // [RULE_04]
    assign win_end  = (meth_ff != pfm_pkg::METH_STD) && (win_cnt_ff == win_len - 1);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            win_cnt_ff  <= 32'h0000_0000;
            edge_cnt_ff <= 32'h0000_0000;
        end else if (meth_chg || win_end) begin
            win_cnt_ff  <= 32'h0000_0000;
            edge_cnt_ff <= 32'h0000_0000;
        end else begin
            win_cnt_ff  <= win_cnt_ff + 32'h0000_0001;
            edge_cnt_ff <= nxt_edge; // [RULE_04]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rep_freq_ff <= 32'h0000_0000;
        end else if (meth_ff == pfm_pkg::METH_STD) begin
            rep_freq_ff <= std_freq_ff; // [RULE_03]
        end else if (win_end) begin
            if (win_freq < pfm_pkg::LOW_FREQ_HZ) begin
                rep_freq_ff <= std_freq_ff; // [RULE_06]
            end else begin
                rep_freq_ff <= sat(win_freq, freq_max); // [RULE_07] [RULE_01] [RULE_02]
            end
        end
    end

    // counter reset during a window marks that window unreliable; set wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bad_cur_ff  <= 1'b0;
            last_bad_ff <= 1'b0;
        end else begin
            if (win_end) begin
                last_bad_ff <= bad_cur_ff | cnt_reset; // [RULE_08]
            end
            if (win_end || meth_chg) begin
                bad_cur_ff <= cnt_reset;
            end else if (cnt_reset) begin
                bad_cur_ff <= 1'b1; // [RULE_08]
            end
        end
    end

    // -------------------------------------------------------------
    // command decode
    // -------------------------------------------------------------
    assign rd_go = ph_wr_ff && (ph_addr_ff == pfm_pkg::REG_READ_CMD) && (state_ff == pfm_pkg::CMD_IDLE);
    assign cv_go = ph_wr_ff && (ph_addr_ff == pfm_pkg::REG_CONV_CMD) && (state_ff == pfm_pkg::CMD_IDLE);

    always_comb begin
        c_err  = 1'b0;
        c_win  = 1'b0;
        c_div  = 1'b0;
        c_res  = result_ff;
        c_meth = meth_ff;
        c_a    = rep_freq_ff;
        c_mul  = pfm_pkg::MUL_RPS;
        if (rd_go) begin
            if (hwdata[15:0] == pfm_pkg::RD_CMP) begin
                if (hwdata[31:16] != pfm_pkg::PORT_HSC0 || !cmp_active) begin
                    c_err = 1'b1;
                end else begin
                    c_res = cmp_results; // [RULE_10]
                end
            end else if (hwdata[15:0] == pfm_pkg::RD_FREQ_STD &&
                         hwdata[31:16] <= pfm_pkg::PORT_POUT_LAST) begin
                c_res = pout_freq[{hwdata[17:16], 5'h00} +: 32]; // [RULE_09]
            end else if ((hwdata[15:0] == pfm_pkg::RD_FREQ_STD ||
                          hwdata[15:0] == pfm_pkg::RD_FREQ_10 ||
                          hwdata[15:0] == pfm_pkg::RD_FREQ_100 ||
                          hwdata[15:0] == pfm_pkg::RD_FREQ_1S) &&
                         hwdata[31:16] == pfm_pkg::PORT_HSC0 && cnt_enabled) begin // [RULE_17]
                c_meth = pfm_pkg::pfm_meth_t'(hwdata[5:4]); // [RULE_05]
                c_res  = rep_freq_ff; // [RULE_09]
                c_win  = (hwdata[5:4] != 2'h0);
            end else begin
                c_err = 1'b1; // [RULE_17]
            end
        end else if (cv_go) begin
            if (!cnt_enabled || hwdata[31:16] == 16'h0000 || hwdata[15:12] != 4'h0) begin
                c_err = 1'b1; // [RULE_15] [RULE_14]
            end else if (hwdata[3:0] == 4'h0) begin // [RULE_11]
                if (hwdata[7:4] > pfm_pkg::METH_MAX || hwdata[11:8] > pfm_pkg::UNIT_MAX) begin
                    c_err = 1'b1; // [RULE_15]
                end else begin
                    c_meth = pfm_pkg::pfm_meth_t'(hwdata[5:4]); // [RULE_12]
                    c_win  = (hwdata[5:4] != 2'h0);
                    c_div  = 1'b1;
                    if (hwdata[9:8] == 2'h0) begin
                        c_mul = pfm_pkg::MUL_RPM; // [RULE_13] [RULE_18]
                    end else if (hwdata[9:8] == 2'h2) begin
                        c_mul = pfm_pkg::MUL_RPH; // [RULE_13]
                    end
                end
            end else if (hwdata[15:0] == pfm_pkg::CONV_TOTAL) begin
                c_a   = cnt_pv; // [RULE_19]
                c_div = 1'b1;
            end else begin
                c_err = 1'b1; // [RULE_15]
            end
        end
    end

    assign meth_chg = (c_meth != meth_ff);

    pfm_div u_cdiv (
        .clk      (hclk),
        .rst_n    (hresetn),
        .start    (c_div),
        .dividend (c_a),
        .divisor  ({16'h0000, hwdata[31:16]}),
        .busy     (),
        .done     (cdiv_done),
        .quot     (cdiv_q)
    );

    // -------------------------------------------------------------
    // command state and results
    // -------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff    <= pfm_pkg::CMD_IDLE;
            meth_ff     <= pfm_pkg::METH_STD;
            rd_cmd_ff   <= 32'h0000_0000;
            conv_cmd_ff <= 32'h0000_0000;
            result_ff   <= 32'h0000_0000;
            err_ff      <= 1'b0;
            cy_ff       <= 1'b0;
            done_ff     <= 1'b0;
            mul_ff      <= pfm_pkg::MUL_RPS;
        end else begin
            meth_ff <= c_meth;
            if (rd_go) begin
                rd_cmd_ff <= hwdata;
            end
            if (cv_go) begin
                conv_cmd_ff <= hwdata;
            end
            if (rd_go || cv_go) begin
                err_ff    <= c_err; // [RULE_15]
                cy_ff     <= !c_err && c_win && last_bad_ff; // [RULE_08]
                result_ff <= c_res;
                mul_ff    <= c_mul;
                done_ff   <= !c_div;
                state_ff  <= c_div ? pfm_pkg::CMD_CALC : pfm_pkg::CMD_IDLE;
            end else if (state_ff == pfm_pkg::CMD_CALC && cdiv_done) begin
                result_ff <= 32'(cdiv_q * mul_ff); // [RULE_18] [RULE_16] [RULE_20]
                done_ff   <= 1'b1;
                state_ff  <= pfm_pkg::CMD_IDLE;
            end
        end
    end

    // -------------------------------------------------------------
    // AHB-Lite slave
    // -------------------------------------------------------------
    assign acc = hsel && htrans[1] && hready;

    always_comb begin
        if (haddr[7:0] == pfm_pkg::REG_READ_CMD) begin
            rd_mux = rd_cmd_ff;
        end else if (haddr[7:0] == pfm_pkg::REG_CONV_CMD) begin
            rd_mux = conv_cmd_ff;
        end else if (haddr[7:0] == pfm_pkg::REG_RESULT_LO) begin
            rd_mux = {16'h0000, result_ff[15:0]}; // [RULE_16]
        end else if (haddr[7:0] == pfm_pkg::REG_RESULT_HI) begin
            rd_mux = {16'h0000, result_ff[31:16]}; // [RULE_16]
        end else if (haddr[7:0] == pfm_pkg::REG_STATUS) begin
            rd_mux = 32'h0000_0000;
            rd_mux[pfm_pkg::ST_DONE] = done_ff;
            rd_mux[pfm_pkg::ST_ERR]  = err_ff;
            rd_mux[pfm_pkg::ST_CY]   = cy_ff;
            rd_mux[pfm_pkg::ST_BUSY] = (state_ff == pfm_pkg::CMD_CALC);
        end else begin
            rd_mux = 32'h0000_0000;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_wr_ff   <= 1'b0;
            ph_addr_ff <= 8'h00;
            hrdata     <= 32'h0000_0000;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
        end else begin
            ph_wr_ff   <= acc && hwrite;
            ph_addr_ff <= haddr[7:0];
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
            if (acc && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end
endmodule // pfm_top

// ---- verif/pfm_pulse_src.sv ----
// pulse source model standing on counter input 0
module pfm_pulse_src (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [31:0] period,
    output logic             strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] cnt_ff;
    // one strobe every period cycles, silent while period is zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 32'h0;
            strobe <= 1'b0;
        end else begin
            strobe <= (period != 32'h0) && (cnt_ff == 32'h0);
            cnt_ff <= (cnt_ff + 32'h1 >= period) ? 32'h0 : cnt_ff + 32'h1;
        end
    end
endmodule // pfm_pulse_src

// ---- verif/pfm_top_checker.sv ----
// checker: bus and result relations at the meter's ports
module pfm_top_checker (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        cmp_active,
    input wire logic [31:0] cmp_results
);
    timeunit 1ns;
    timeprecision 1ps;
    // ---------------------------------------------
    // transfer decode
    // ---------------------------------------------
    logic        rd_t;
    logic        wr_t;
    logic [15:0] cmp_lo;
    assign rd_t   = hsel && htrans[1] && hready && !hwrite;
    assign wr_t   = hsel && htrans[1] && hready && hwrite;
    assign cmp_lo = cmp_results[15:0];
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_cmd;
        wr_t && haddr[7:0] == pfm_pkg::REG_READ_CMD;
    endsequence
    sequence s_poll;
        rd_t && haddr[7:0] == pfm_pkg::REG_STATUS;
    endsequence
    a_ready_always: assert property (hreadyout) else $error("wait state inserted");
    a_resp_okay: assert property (!hresp) else $error("error response");
    a_rdata_hold: assert property (!rd_t |=> $stable(hrdata)) else $error("read data moved");
    a_unmapped_zero: assert property (rd_t && haddr[7:0] > 8'h10 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_result_halves:
        assert property (rd_t && haddr[7:0] inside {8'h08, 8'h0C} |=> hrdata[31:16] == 16'h0)
        else $error("result word upper half set");
    a_status_upper: assert property (s_poll |=> hrdata[31:4] == 28'h0)
        else $error("status upper bits set");
    a_cmp_read:
        assert property (s_cmd ##1 (hwdata == 32'h0010_0002 && cmp_active) ##1 rd_t
            ##2 (rd_t && haddr[7:0] == pfm_pkg::REG_RESULT_LO)
            |=> hrdata == {16'h0, $past(cmp_lo, 4)}) else $error("comparison bits wrong");
    a_bad_port:
        assert property (s_cmd ##1 !(hwdata[31:16] <= 16'h0003 || hwdata[31:16] == 16'h0010)
            ##1 s_poll |=> hrdata[pfm_pkg::ST_ERR]) else $error("bad port not flagged");
endmodule // pfm_top_checker

bind pfm_top pfm_top_checker chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .cmp_active, .cmp_results);

// ---- verif/tb_top.sv ----
// self-checking bench for the frequency meter and speed converter
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fail_count++; \
    $display("unexpected t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ---------------------------------------------
    // signals and instances
    // ---------------------------------------------
    localparam int W10 = 1000, W100 = 4000, W1S = 8000;
    localparam logic [7:0] RD = pfm_pkg::REG_READ_CMD, CV = pfm_pkg::REG_CONV_CMD;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, cnt_strobe;
    logic cnt_reset = 1'b0, cnt_enabled = 1'b1, four_x_mode = 1'b0, cmp_active = 1'b0;
    logic [1:0]   htrans = 2'h0;
    logic [31:0]  haddr = 32'h0, hwdata = 32'h0, hrdata, cnt_pv = 32'h0, period = 32'h0;
    logic [31:0]  cmp_results = 32'h5A3C_0F96;
    logic [127:0] pout_freq = {32'h0001_86A0, 32'h0000_C350, 32'h0000_1388, 32'h0000_0001};
    int fail_count = 0, check_count = 0, cycles = 0;
    pfm_top #(.WIN10_CYC(W10), .WIN100_CYC(W100), .WIN1S_CYC(W1S), .STD_TIMEOUT_CYC(20000))
    dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .cnt_strobe, .cnt_reset,
        .cnt_enabled, .four_x_mode, .cnt_pv, .cmp_active, .cmp_results, .pout_freq);
    pfm_pulse_src src_u (.clk(hclk), .rst_n(hresetn), .period, .strobe(cnt_strobe));
    always #4 hclk = ~hclk;
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 80000) begin
            fail_count++;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    // command write, poll until idle, then both result words
    task automatic run(input logic [7:0] a, input logic [31:0] c, output logic [31:0] r,
                       output logic [31:0] s);
        logic [31:0] lo, hi;
        int n;
        bus(1'b1, a, c, lo);
        n = 0;
        do begin
            bus(1'b0, pfm_pkg::REG_STATUS, 32'h0, s);
            n++;
        end while (s[pfm_pkg::ST_BUSY] !== 1'b0 && n < 100);
        bus(1'b0, pfm_pkg::REG_RESULT_LO, 32'h0, lo);
        bus(1'b0, pfm_pkg::REG_RESULT_HI, 32'h0, hi);
        r = {hi[15:0], lo[15:0]};
    endtask
    // ---------------------------------------------
    // scenarios
    // ---------------------------------------------
    task automatic t_reset();
        logic [31:0] q;
        logic [7:0] adr [4] = '{8'h08, 8'h0C, 8'h10, 8'hFC};
        bus(1'b1, 8'hFC, 32'hFFFF_FFFF, q);
        foreach (adr[i]) begin
            bus(1'b0, adr[i], 32'h0, q);
            `CHK(q, 32'h0)
        end
    endtask
    task automatic t_pout();
        logic [31:0] r, s;
        for (int p = 0; p < 4; p++) begin
            run(RD, {16'(p), 16'h0003}, r, s);
            `CHK(r, pout_freq[32*p +: 32])
        end
        cmp_active <= 1'b1;
        run(RD, 32'h0010_0002, r, s);
        `CHK(r, cmp_results)
        cmp_active <= 1'b0;
        run(RD, 32'h0010_0002, r, s);
        `CHK(s[pfm_pkg::ST_ERR], 1'b1)
    endtask
    task automatic t_std();
        logic [31:0] r, s;
        int per [4] = '{1250, 2500, 40, 40};
        logic [31:0] ex [4] = '{32'd100000, 32'd50000, 32'h0001_86A0, 32'h0003_0D40};
        foreach (per[i]) begin
            period <= per[i];
            four_x_mode <= (i == 3);
            idle(3 * per[i] + 200);
            run(RD, 32'h0010_0003, r, s);
            `CHK(r, ex[i])
        end
    endtask
    task automatic t_win();
        logic [31:0] r, s;
        int win [3] = '{W10, W100, W1S};
        logic [15:0] code [3] = '{16'h0013, 16'h0023, 16'h0033};
        logic [31:0] ex [3] = '{32'd2500, 32'd1000, 32'd100000};
        four_x_mode <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            run(RD, {16'h0010, code[i]}, r, s);
            idle(2 * win[i] + 50);
            run(RD, {16'h0010, code[i]}, r, s);
            `CHK(r, ex[i])
            `CHK(s[pfm_pkg::ST_CY], 1'b0)
            run(CV, {16'h0007, code[i] - 16'h0003}, r, s);
            `CHK(r, ex[i] / 7 * 60)
        end
    endtask
    task automatic t_carry();
        logic [31:0] r, s;
        run(RD, 32'h0010_0013, r, s);
        idle(2 * W10);
        repeat (4) begin
            cnt_reset <= 1'b1;
            idle(1);
            cnt_reset <= 1'b0;
            idle(499);
        end
        run(RD, 32'h0010_0013, r, s);
        `CHK(s[pfm_pkg::ST_CY], 1'b1)
        idle(2 * W10 + 100);
        run(RD, 32'h0010_0013, r, s);
        `CHK(s[pfm_pkg::ST_CY], 1'b0)
    endtask
    task automatic t_conv();
        logic [31:0] r, s;
        int mul [3] = '{60, 1, 3600};
        period <= 32'd1250;
        run(RD, 32'h0010_0003, r, s);
        idle(4000);
        for (int i = 0; i < 3; i++) begin
            run(CV, {16'h0007, 16'(i * 256)}, r, s);
            `CHK(r, 32'd100000 / 7 * mul[i])
        end
        cnt_pv <= 32'hFFFF_FFFF;
        run(CV, 32'hFFFF_0001, r, s);
        `CHK(r, 32'h0001_0001)
        cnt_pv <= 32'h0012_3456;
        run(CV, 32'h0100_0001, r, s);
        `CHK(r, 32'h0000_1234)
    endtask
    task automatic t_bad();
        logic [31:0] r, s;
        logic [31:0] rb [5] = '{32'h0011_0003, 32'h0004_0003, 32'h0000_0013, 32'h0010_0001,
                                32'h0100_0033};
        logic [31:0] cb [5] = '{32'h0, 32'h0007_0300, 32'h0007_0002, 32'h0007_0040,
                                32'h0007_1000};
        run(RD, 32'h0000_0003, r, s);
        foreach (rb[i]) begin
            run(RD, rb[i], r, s);
            `CHK(s[pfm_pkg::ST_ERR], 1'b1)
            `CHK(r, pout_freq[31:0])
            run(CV, cb[i], r, s);
            `CHK(s[pfm_pkg::ST_ERR], 1'b1)
        end
        cnt_enabled <= 1'b0;
        run(RD, 32'h0010_0003, r, s);
        `CHK(s[pfm_pkg::ST_ERR], 1'b1)
        run(CV, 32'h0007_0000, r, s);
        `CHK(s[pfm_pkg::ST_ERR], 1'b1)
        cnt_enabled <= 1'b1;
        run(CV, 32'h0007_0000, r, s);
        `CHK(s[3:0], 4'h1)
    endtask
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_pout();
        t_std();
        t_win();
        t_carry();
        t_conv();
        t_bad();
        summarize();
    end
endmodule // tb_top
